// >>> design/dll_pkg.sv
package dll_pkg;
   // Word and sequence geometry
   localparam int SEQ_W = 12;
   localparam int SLOTS = 8;
   localparam int MAX_WORDS = 8;
   localparam logic [11:0] SLOTS_SEQ = 12'h008;
   localparam logic [3:0] LAST_IDX = 4'h7;
   // CRC polynomials and seeds
   localparam logic [31:0] LCRC_POLY = 32'h04C11DB7;
   localparam logic [31:0] LCRC_INIT = 32'hFFFFFFFF;
   localparam logic [15:0] DCRC_POLY = 16'h100B;
   localparam logic [15:0] DCRC_INIT = 16'hFFFF;
   // Link packet type codes, bits 31:24 of the first word
   localparam logic [7:0] DLLP_ACK = 8'h00;
   localparam logic [7:0] DLLP_NAK = 8'h10;
   localparam logic [7:0] DLLP_FC = 8'h40;
   // Replay timer
   localparam int CLK_PERIOD_NS = 10;
   localparam int REPLAY_TIME_NS = 1000;
   localparam int REPLAY_CYC = REPLAY_TIME_NS / CLK_PERIOD_NS;
   localparam logic [11:0] TIMER_LAST = 12'(REPLAY_CYC - 1);

   typedef enum logic [1:0] {TX_IDLE, TX_DLLP_CRC, TX_DATA, TX_CRC} tx_state_t;

   typedef struct packed {
      tx_state_t st;
      logic rp;
      logic rp_pend;
      logic [11:0] seq_out;
      logic [3:0] idx;
      logic [31:0] tcrc;
      logic [15:0] dcrc;
      logic [11:0] next_seq;
      logic [11:0] una;
      logic [7:0][3:0] lens;
      logic [11:0] timer;
      logic [3:0] ridx;
      logic [11:0] rseq;
      logic [31:0] rcrc;
      logic [11:0] next_rcv;
      logic [31:0] rdw0;
      logic rdhave;
      logic ack_pend;
      logic ack_nak;
      logic [11:0] ack_seq;
      logic fc_pend;
      logic [23:0] fc_data;
      logic lk_tx_valid;
      logic [31:0] lk_tx_data;
      logic lk_tx_last;
      logic lk_tx_dllp;
      logic tl_rx_valid;
      logic [31:0] tl_rx_data;
      logic tl_rx_end;
      logic tl_rx_good;
      logic fc_rx_valid;
      logic [23:0] fc_rx_data;
   } dll_state_t;

   // Word-wide CRC-32, MSB first
   function automatic logic [31:0] crc32_word(input logic [31:0] crc, input logic [31:0] data);
      logic [31:0] c;
      c = crc;
      for (int i = 31; i >= 0; i--) begin
         c = (c[31] ^ data[i]) ? ((c << 1) ^ LCRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc32_word

   // Word-wide CRC-16, MSB first
   function automatic logic [15:0] crc16_word(input logic [15:0] crc, input logic [31:0] data);
      logic [15:0] c;
      c = crc;
      for (int i = 31; i >= 0; i--) begin
         c = (c[15] ^ data[i]) ? ((c << 1) ^ DCRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc16_word
endpackage : dll_pkg

// >>> design/dll_ack_replay.sv
// Overview of operation
// - Every sent TLP ends with a 32-bit LCRC word.
// - Receive side recomputes LCRC over each incoming TLP and compares.
// - Received TLP with bad LCRC causes a NACK DLLP.
// - Received TLP with good LCRC causes an ACK DLLP.
// - Every sent TLP stays in the retry buffer until acknowledged.
// - ACK releases all stored TLPs with sequence up to the carried one.
// - NACK or replay timer expiry starts a replay.
// - Replay resends the oldest unacked TLP and all later ones in order.
// - Flow-control credits travel both ways in DLLPs.
// - Each DLLP carries a 16-bit CRC, checked on receipt.
`timescale 1ns/10ps
`default_nettype none
module dll_ack_replay
   import dll_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tl_tx_valid,
   input wire logic [31:0] tl_tx_data,
   input wire logic tl_tx_last,
   output logic tl_tx_ready,
   output logic tl_rx_valid,
   output logic [31:0] tl_rx_data,
   output logic tl_rx_end,
   output logic tl_rx_good,
   input wire logic fc_tx_req,
   input wire logic [23:0] fc_tx_data,
   output logic fc_tx_ready,
   output logic fc_rx_valid,
   output logic [23:0] fc_rx_data,
   output logic lk_tx_valid,
   output logic [31:0] lk_tx_data,
   output logic lk_tx_last,
   output logic lk_tx_dllp,
   input wire logic lk_rx_valid,
   input wire logic [31:0] lk_rx_data,
   input wire logic lk_rx_last,
   input wire logic lk_rx_dllp
);
   dll_state_t q, d;
   logic [31:0] rbuf [SLOTS*MAX_WORDS];
   logic [31:0] rbuf_rd;
   logic [11:0] inflight;
   logic dl_ok;
   logic [7:0] dl_type;
   logic [11:0] dl_seq;
   logic ack_hit;
   logic rx_tlp_end;
   logic rx_crc_ok;
   logic replay_go;
   logic new_go;
   logic wr_en;

   // Event decode shared by the next-state logic and the checks
   assign inflight = q.next_seq - q.una;
   assign dl_type = q.rdw0[31:24];
   assign dl_seq = q.rdw0[11:0];
   assign dl_ok = lk_rx_valid && lk_rx_dllp && lk_rx_last && q.rdhave &&
                  (crc16_word(DCRC_INIT, q.rdw0) == lk_rx_data[15:0]);
   assign ack_hit = dl_ok && (dl_type == DLLP_ACK || dl_type == DLLP_NAK) &&
                    ((dl_seq - q.una) < inflight);
   assign rx_tlp_end = lk_rx_valid && !lk_rx_dllp && lk_rx_last && (q.ridx != 4'h0);
   assign rx_crc_ok = (~q.rcrc == lk_rx_data);
   assign replay_go = (q.st == TX_IDLE) && !q.ack_pend && !q.fc_pend && q.rp_pend && (inflight != 12'h000);
   assign new_go = (q.st == TX_IDLE) && !q.ack_pend && !q.fc_pend && !replay_go &&
                   !(q.rp && q.rp_pend == 1'b0 && ((q.seq_out + 12'h001 - q.una) < inflight)) &&
                   tl_tx_valid && (inflight < SLOTS_SEQ);
   assign tl_tx_ready = (q.st == TX_DATA) && !q.rp;
   assign fc_tx_ready = !q.fc_pend;
   assign wr_en = tl_tx_valid && tl_tx_ready;
   assign rbuf_rd = rbuf[{q.seq_out[2:0], q.idx[2:0]}];

   // Retry buffer store, one slot per outstanding sequence number
   always_ff @(posedge clock) begin
      if (wr_en) begin
         rbuf[{q.seq_out[2:0], q.idx[2:0]}] <= tl_tx_data;
      end
   end

   // Next-state logic: transmit side, then acknowledge handling, then receive side
   always_comb begin
      logic [31:0] w0;
      w0 = 32'h00000000;
      d = q;
      d.lk_tx_valid = 1'b0;
      d.lk_tx_last = 1'b0;
      d.lk_tx_dllp = 1'b0;
      d.tl_rx_valid = 1'b0;
      d.tl_rx_end = 1'b0;
      d.fc_rx_valid = 1'b0;
      // Transmit arbiter and framer; words leave on lk_tx_data
      unique case (q.st)
         TX_IDLE: begin
            if (q.ack_pend || q.fc_pend) begin
               w0 = q.ack_pend ? {(q.ack_nak ? DLLP_NAK : DLLP_ACK), 12'h000, q.ack_seq} : {DLLP_FC, q.fc_data};
               d.ack_pend = 1'b0;
               d.fc_pend = q.ack_pend ? q.fc_pend : 1'b0;
               d.dcrc = crc16_word(DCRC_INIT, w0);
               d.lk_tx_valid = 1'b1;
               d.lk_tx_dllp = 1'b1;
               d.lk_tx_data = w0;
               d.st = TX_DLLP_CRC;
            end else if (replay_go || (q.rp && ((q.seq_out + 12'h001 - q.una) < inflight)) || new_go) begin
               if (replay_go) begin
                  d.seq_out = q.una;
                  d.rp = 1'b1;
                  d.rp_pend = 1'b0;
               end else if (new_go) begin
                  d.seq_out = q.next_seq;
                  d.next_seq = q.next_seq + 12'h001;
                  d.rp = 1'b0;
               end else begin
                  d.seq_out = q.seq_out + 12'h001;
               end
               w0 = {20'h00000, d.seq_out};
               d.tcrc = crc32_word(LCRC_INIT, w0);
               d.idx = 4'h0;
               d.lk_tx_valid = 1'b1;
               d.lk_tx_data = w0;
               d.st = TX_DATA;
            end else begin
               d.rp = 1'b0;
               d.rp_pend = 1'b0;
            end
         end
         TX_DLLP_CRC: begin
            d.lk_tx_valid = 1'b1;
            d.lk_tx_dllp = 1'b1;
            d.lk_tx_last = 1'b1;
            d.lk_tx_data = {16'h0000, q.dcrc};
            d.st = TX_IDLE;
         end
         TX_DATA: begin
            if (q.rp || tl_tx_valid) begin
               w0 = q.rp ? rbuf_rd : tl_tx_data;
               d.lk_tx_valid = 1'b1;
               d.lk_tx_data = w0;
               d.tcrc = crc32_word(q.tcrc, w0);
               if (q.rp ? (q.idx + 4'h1 == q.lens[q.seq_out[2:0]]) : (tl_tx_last || q.idx == LAST_IDX)) begin
                  if (!q.rp) begin
                     d.lens[q.seq_out[2:0]] = q.idx + 4'h1;
                  end
                  d.st = TX_CRC;
               end else begin
                  d.idx = q.idx + 4'h1;
               end
            end
         end
         TX_CRC: begin
            d.lk_tx_valid = 1'b1;
            d.lk_tx_last = 1'b1;
            d.lk_tx_data = ~q.tcrc;
            d.st = TX_IDLE;
         end
      endcase
      // Received DLLP: two words, content then CRC
      if (lk_rx_valid && lk_rx_dllp) begin
         d.rdhave = !lk_rx_last;
         if (!lk_rx_last) begin
            d.rdw0 = lk_rx_data;
         end
      end
      if (ack_hit) begin
         d.una = dl_seq + 12'h001;
      end
      if (dl_ok && dl_type == DLLP_NAK && (q.next_seq != (ack_hit ? dl_seq + 12'h001 : q.una))) begin
         d.rp_pend = 1'b1;
      end
      if (dl_ok && dl_type == DLLP_FC) begin
         d.fc_rx_valid = 1'b1;
         d.fc_rx_data = q.rdw0[23:0];
      end
      // Replay timer runs while anything is unacknowledged
      if (inflight == 12'h000 || ack_hit) begin
         d.timer = 12'h000;
      end else if (q.timer == TIMER_LAST) begin
         d.timer = 12'h000;
         d.rp_pend = 1'b1;
      end else begin
         d.timer = q.timer + 12'h001;
      end
      // Received TLP: sequence word, payload, LCRC word
      if (lk_rx_valid && !lk_rx_dllp) begin
         if (q.ridx == 4'h0) begin
            d.rseq = lk_rx_data[11:0];
            d.rcrc = crc32_word(LCRC_INIT, lk_rx_data);
            d.ridx = lk_rx_last ? 4'h0 : 4'h1;
         end else if (!lk_rx_last) begin
            d.rcrc = crc32_word(q.rcrc, lk_rx_data);
            d.tl_rx_valid = 1'b1;
            d.tl_rx_data = lk_rx_data;
            d.ridx = (q.ridx == 4'hF) ? q.ridx : q.ridx + 4'h1;
         end else begin
            d.ridx = 4'h0;
            d.tl_rx_end = 1'b1;
            d.tl_rx_good = rx_crc_ok && (q.rseq == q.next_rcv);
            d.ack_pend = 1'b1;
            d.ack_nak = !rx_crc_ok;
            d.ack_seq = (rx_crc_ok && q.rseq == q.next_rcv) ? q.rseq : q.next_rcv - 12'h001;
            if (rx_crc_ok && q.rseq == q.next_rcv) begin
               d.next_rcv = q.next_rcv + 12'h001;
            end
         end
      end
      // A new credit request is taken only while none is pending, so it never overwrites one being sent
      if (fc_tx_req && !q.fc_pend) begin
         d.fc_pend = 1'b1;
         d.fc_data = fc_tx_data;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tl_rx_valid = q.tl_rx_valid;
   assign tl_rx_data = q.tl_rx_data;
   assign tl_rx_end = q.tl_rx_end;
   assign tl_rx_good = q.tl_rx_good;
   assign fc_rx_valid = q.fc_rx_valid;
   assign fc_rx_data = q.fc_rx_data;
   assign lk_tx_valid = q.lk_tx_valid;
   assign lk_tx_data = q.lk_tx_data;
   assign lk_tx_last = q.lk_tx_last;
   assign lk_tx_dllp = q.lk_tx_dllp;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_bad_end;
      rx_tlp_end && !rx_crc_ok;
   endsequence
   sequence s_dllp_hdr;
      lk_tx_valid && lk_tx_dllp && !lk_tx_last;
   endsequence
   sequence s_dllp_crc;
      lk_tx_valid && lk_tx_dllp && lk_tx_last && (lk_tx_data[15:0] == crc16_word(DCRC_INIT, $past(lk_tx_data)));
   endsequence

   property p_rx_check;
      s_bad_end |=> tl_rx_end && !tl_rx_good;
   endproperty
   a_rx_check: assert property (p_rx_check) else $error("bad LCRC reported good");
   property p_nak_bad;
      s_bad_end |=> q.ack_pend && q.ack_nak && (q.ack_seq == $past(q.next_rcv) - 12'h001);
   endproperty
   a_nak_bad: assert property (p_nak_bad) else $error("no NACK queued after bad LCRC");
   property p_ack_good;
      rx_tlp_end && rx_crc_ok && q.rseq == q.next_rcv |=> q.ack_pend && !q.ack_nak && q.ack_seq == $past(q.rseq);
   endproperty
   a_ack_good: assert property (p_ack_good) else $error("no ACK queued after good TLP");
   property p_hold;
      !ack_hit |=> q.una == $past(q.una);
   endproperty
   a_hold: assert property (p_hold) else $error("retry slot released without ACK");
   property p_release;
      ack_hit |=> q.una == $past(dl_seq) + 12'h001 && q.timer == 12'h000;
   endproperty
   a_release: assert property (p_release) else $error("ACK did not release up to its sequence");
   property p_timeout;
      q.timer == TIMER_LAST && inflight != 12'h000 && !ack_hit |=> q.rp_pend;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timer expiry did not request replay");
   property p_replay_start;
      replay_go |=> lk_tx_valid && !lk_tx_dllp && lk_tx_data[11:0] == $past(q.una) && q.rp;
   endproperty
   a_replay_start: assert property (p_replay_start) else $error("replay not from oldest unacked TLP");
   property p_new_seq;
      new_go |=> lk_tx_data[11:0] == $past(q.next_seq) && q.next_seq == $past(q.next_seq) + 12'h001;
   endproperty
   a_new_seq: assert property (p_new_seq) else $error("new TLP sequence not next in order");
   property p_dllp_crc;
      s_dllp_hdr |-> ##1 s_dllp_crc;
   endproperty
   a_dllp_crc: assert property (p_dllp_crc) else $error("DLLP CRC word wrong");
endmodule : dll_ack_replay
`default_nettype wire

// >>> bench/link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module link_partner
   import dll_pkg::*;
(
   input wire logic clock,
   input wire logic lk_tx_valid,
   input wire logic [31:0] lk_tx_data,
   input wire logic lk_tx_last,
   input wire logic lk_tx_dllp,
   output logic lk_rx_valid,
   output logic [31:0] lk_rx_data,
   output logic lk_rx_last,
   output logic lk_rx_dllp
);
   logic [33:0] txq[$];
   logic [96:0] fq[$];
   logic [31:0] cw[0:1];
   int fn = 0;
   bit auto_ack = 1'b0;

   // Own CRC steps, independent of the block's
   function automatic logic [31:0] c32(input logic [31:0] c, input logic [31:0] d);
      for (int i = 31; i >= 0; i--) c = (c[31] ^ d[i]) ? ((c << 1) ^ LCRC_POLY) : (c << 1);
      return c;
   endfunction : c32

   function automatic logic [15:0] c16(input logic [15:0] c, input logic [31:0] d);
      for (int i = 31; i >= 0; i--) c = (c[15] ^ d[i]) ? ((c << 1) ^ DCRC_POLY) : (c << 1);
      return c;
   endfunction : c16

   // One-word packet, optionally with a broken LCRC
   task automatic push_tlp(input logic [11:0] seq, input logic [31:0] d, input bit bad);
      logic [31:0] c;
      c = c32(c32(LCRC_INIT, {20'h0, seq}), d);
      txq.push_back({2'b00, 20'h0, seq});
      txq.push_back({2'b00, d});
      txq.push_back({2'b01, ~c ^ {31'h0, bad}});
   endtask : push_tlp

   // Link packet, optionally with a broken CRC
   task automatic push_dllp(input logic [7:0] typ, input logic [23:0] ct, input bit bad);
      txq.push_back({2'b10, typ, ct});
      txq.push_back({2'b11, 16'h0, c16(DCRC_INIT, {typ, ct}) ^ {15'h0, bad}});
   endtask : push_dllp

   // Word driver; idle data toggles so no stale word survives
   initial begin
      lk_rx_valid = 1'b0;
      lk_rx_data = 32'h0;
      lk_rx_last = 1'b0;
      lk_rx_dllp = 1'b0;
   end
   always @(posedge clock) begin
      if (txq.size() > 0) begin
         {lk_rx_dllp, lk_rx_last, lk_rx_data} <= txq.pop_front();
         lk_rx_valid <= 1'b1;
      end else begin
         {lk_rx_valid, lk_rx_last, lk_rx_dllp} <= 3'h0;
         lk_rx_data <= ~lk_rx_data;
      end
   end

   // Frame collector, with prompt acknowledge when enabled
   always @(posedge clock) begin
      if (lk_tx_valid) begin
         if (lk_tx_last) begin
            fq.push_back({lk_tx_dllp, cw[0], cw[1], lk_tx_data});
            if (auto_ack && !lk_tx_dllp) push_dllp(DLLP_ACK, {12'h0, cw[0][11:0]}, 1'b0);
            fn = 0;
         end else begin
            if (fn < 2) cw[fn] = lk_tx_data;
            fn++;
         end
      end
   end
endmodule : link_partner
`default_nettype wire

// >>> bench/test_dll_ack_replay.sv
`timescale 1ns/10ps
`default_nettype none
module test_dll_ack_replay
   import dll_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic tl_tx_valid = 1'b0;
   logic [31:0] tl_tx_data = 32'h0;
   logic tl_tx_last = 1'b0;
   logic fc_tx_req = 1'b0;
   logic [23:0] fc_tx_data = 24'h0;
   logic tl_tx_ready, tl_rx_valid, tl_rx_end, tl_rx_good, fc_tx_ready, fc_rx_valid;
   logic [31:0] tl_rx_data, lk_tx_data, lk_rx_data;
   logic [23:0] fc_rx_data;
   logic lk_tx_valid, lk_tx_last, lk_tx_dllp, lk_rx_valid, lk_rx_last, lk_rx_dllp;
   int num_errors = 0;
   int num_checks = 0;
   int rx_ends = 0;
   int fc_cnt = 0;
   logic rx_good;
   logic [31:0] rx_word;
   logic [23:0] fc_word;

   dll_ack_replay u_dll_ack_replay (.clock(clock), .rst_n(rst_n), .tl_tx_valid(tl_tx_valid),
      .tl_tx_data(tl_tx_data), .tl_tx_last(tl_tx_last), .tl_tx_ready(tl_tx_ready), .tl_rx_valid(tl_rx_valid),
      .tl_rx_data(tl_rx_data), .tl_rx_end(tl_rx_end), .tl_rx_good(tl_rx_good), .fc_tx_req(fc_tx_req),
      .fc_tx_data(fc_tx_data), .fc_tx_ready(fc_tx_ready), .fc_rx_valid(fc_rx_valid), .fc_rx_data(fc_rx_data),
      .lk_tx_valid(lk_tx_valid), .lk_tx_data(lk_tx_data), .lk_tx_last(lk_tx_last), .lk_tx_dllp(lk_tx_dllp),
      .lk_rx_valid(lk_rx_valid), .lk_rx_data(lk_rx_data), .lk_rx_last(lk_rx_last), .lk_rx_dllp(lk_rx_dllp));

   link_partner u_link_partner (.clock(clock), .lk_tx_valid(lk_tx_valid), .lk_tx_data(lk_tx_data),
      .lk_tx_last(lk_tx_last), .lk_tx_dllp(lk_tx_dllp), .lk_rx_valid(lk_rx_valid), .lk_rx_data(lk_rx_data),
      .lk_rx_last(lk_rx_last), .lk_rx_dllp(lk_rx_dllp));

   // Clock
   initial begin
      forever #5 clock = ~clock;
   end

   // Receive-side observers
   always @(posedge clock) begin
      if (tl_rx_valid === 1'b1) rx_word = tl_rx_data;
      if (tl_rx_end === 1'b1) begin
         rx_good = tl_rx_good;
         rx_ends++;
      end
      if (fc_rx_valid === 1'b1) begin
         fc_word = fc_rx_data;
         fc_cnt++;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("TB: checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   // Next frame of the wanted kind, skipping others
   task automatic get_frame(input bit dllp, output logic [96:0] r);
      int k;
      k = 0;
      r = '0;
      while (k < 400) begin
         @(negedge clock);
         k++;
         if (u_link_partner.fq.size() > 0) begin
            r = u_link_partner.fq.pop_front();
            if (r[96] == dllp) return;
         end
      end
      check("frame arrival", 32'h0, 32'h1);
   endtask : get_frame

   task automatic chk_tlp(input logic [11:0] seq, input logic [31:0] d);
      logic [96:0] r;
      get_frame(1'b0, r);
      check("tlp seq word", r[95:64], {20'h0, seq});
      check("tlp payload", r[63:32], d);
      check("tlp lcrc", r[31:0], ~u_link_partner.c32(u_link_partner.c32(LCRC_INIT, {20'h0, seq}), d));
   endtask : chk_tlp

   task automatic chk_dllp(input logic [7:0] typ, input logic [23:0] ct);
      logic [96:0] r;
      get_frame(1'b1, r);
      check("dllp word0", r[95:64], {typ, ct});
      check("dllp crc", r[31:0], {16'h0, u_link_partner.c16(DCRC_INIT, {typ, ct})});
   endtask : chk_dllp

   task automatic send_tl(input logic [31:0] d);
      int k;
      @(posedge clock);
      {tl_tx_valid, tl_tx_last} <= 2'b11;
      tl_tx_data <= d;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (tl_tx_ready !== 1'b1 && k < 300);
      check("tl_tx_ready", {31'h0, tl_tx_ready}, 32'h1);
      @(posedge clock);
      {tl_tx_valid, tl_tx_last} <= 2'b00;
   endtask : send_tl

   task automatic wait_end(input int n0);
      for (int k = 0; k < 300 && rx_ends == n0; k++) @(negedge clock);
   endtask : wait_end

   task automatic quiet(input int n);
      repeat (n) @(negedge clock);
      check("no replay", u_link_partner.fq.size(), 32'h0);
   endtask : quiet

   task automatic t_tx_acked();
      u_link_partner.auto_ack = 1'b1;
      send_tl(32'hA5A50001);
      chk_tlp(12'h000, 32'hA5A50001);
      quiet(200);
      $display("TB: tx acked done");
   endtask : t_tx_acked

   task automatic t_rx(input logic [11:0] seq, input bit bad, input logic [7:0] typ);
      int n0;
      n0 = rx_ends;
      u_link_partner.push_tlp(seq, 32'h5A5A0000 | seq, bad);
      wait_end(n0);
      check("rx payload", rx_word, 32'h5A5A0000 | seq);
      check("rx good", {31'h0, rx_good}, {31'h0, ~bad});
      chk_dllp(typ, 24'h000000);
      $display("TB: rx seq %0d bad %0d done", seq, bad);
   endtask : t_rx

   task automatic t_fc();
      int n0;
      @(posedge clock);
      fc_tx_req <= 1'b1;
      fc_tx_data <= 24'h5A5A5A;
      @(posedge clock);
      fc_tx_req <= 1'b0;
      @(negedge clock);
      check("fc_tx_ready busy", {31'h0, fc_tx_ready}, 32'h0);
      chk_dllp(DLLP_FC, 24'h5A5A5A);
      check("fc_tx_ready free", {31'h0, fc_tx_ready}, 32'h1);
      n0 = fc_cnt;
      u_link_partner.push_dllp(DLLP_FC, 24'h123456, 1'b1);
      u_link_partner.push_dllp(DLLP_FC, 24'h00ABCD, 1'b0);
      repeat (20) @(negedge clock);
      check("fc count", fc_cnt - n0, 32'h1);
      check("fc data", {8'h0, fc_word}, 32'h0000ABCD);
      $display("TB: flow control done");
   endtask : t_fc

   task automatic t_replay();
      u_link_partner.auto_ack = 1'b0;
      send_tl(32'h11110001);
      send_tl(32'h22220002);
      chk_tlp(12'h001, 32'h11110001);
      chk_tlp(12'h002, 32'h22220002);
      u_link_partner.push_dllp(DLLP_NAK, 24'h000001, 1'b0);
      chk_tlp(12'h002, 32'h22220002);
      chk_tlp(12'h002, 32'h22220002);
      u_link_partner.push_dllp(DLLP_ACK, 24'h000002, 1'b0);
      repeat (12) @(negedge clock);
      check("no stray frame", u_link_partner.fq.size(), 32'h0);
      quiet(200);
      $display("TB: replay done");
   endtask : t_replay

   // Main sequence
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      t_tx_acked();
      t_rx(12'h000, 1'b0, DLLP_ACK);
      t_rx(12'h001, 1'b1, DLLP_NAK);
      t_fc();
      t_replay();
      close_out();
   end

   // Watchdog
   initial begin
      #200us;
      num_errors++;
      close_out();
   end
endmodule : test_dll_ack_replay
`default_nettype wire
